// ### bench/pdts_host_model.sv
// host model driving register accesses from the pixel network link side
`timescale 1ns/10ps
module pdts_host_model (
    input wire logic mclk,
    output logic reg_wr,
    output logic [7:0] reg_addr,
    output logic [23:0] reg_wdata,
    output logic reg_rd,
    output logic read_ok,
    input wire logic [23:0] reg_rdata
);
    // idle link at time zero; no switch events are issued here
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        read_ok = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 24'h000000;
    end
    // slope bit only set when the caller asks, gentle by default
    task automatic write(input logic [7:0] a, input logic [23:0] d);
        @(posedge mclk) #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge mclk) #1;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    // ok high reports the readout as error free, which clears it
    task automatic read(input logic [7:0] a, input logic ok,
                        output logic [23:0] d);
        @(posedge mclk) #1;
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge mclk) #1;
        reg_rd = 1'b0;
        read_ok = ok;
        d = reg_rdata;
        @(posedge mclk) #1;
        read_ok = 1'b0;
        reg_addr = ~a;
    endtask
endmodule // pdts_host_model

// ### bench/pixel_dimming_timing_status_tb_top.sv
// self-checking bench for the dimming timing and switch status core
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
    fail_count++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
    end end
module pixel_dimming_timing_status_tb_top import pdts_pkg::*;;
    logic mclk, resetn, reg_wr, reg_rd, read_ok, dimming_tick_clock;
    logic pwm_period_start, turn_on_slope_select;
    logic [7:0] reg_addr, transition_tick_reserve;
    logic [23:0] reg_wdata, reg_rdata, switch_diag_state, rd_d, ex;
    logic [3:0] channel_transition_count;
    logic [11:0] switch_diag_valid;
    logic [9:0] pwm_count, end_extension_ticks;
    logic [4:0] switch_event_time;
    logic [5:0] switch_event_spacing;
    logic [5:0] slot[4] = '{6'd41, 6'd20, 6'd9, 6'd4};
    int codes[9] = '{0, 7, 8, 9, 15, 16, 19, 31, 20};
    int fail_count, n_tests, e, b, n, nt;
    pdts_core i_pdts_core (.mclk(mclk), .resetn(resetn), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .read_ok(read_ok), .channel_transition_count(channel_transition_count),
        .switch_diag_state(switch_diag_state),
        .switch_diag_valid(switch_diag_valid), .reg_rdata(reg_rdata),
        .dimming_tick_clock(dimming_tick_clock),
        .pwm_period_start(pwm_period_start), .pwm_count(pwm_count),
        .switch_event_time(switch_event_time),
        .transition_tick_reserve(transition_tick_reserve),
        .switch_event_spacing(switch_event_spacing),
        .end_extension_ticks(end_extension_ticks),
        .turn_on_slope_select(turn_on_slope_select));
    pdts_host_model i_pdts_host_model (.mclk(mclk), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .read_ok(read_ok), .reg_rdata(reg_rdata));
    // 10 MHz clock
    initial mclk = 1'b0;
    always #50 mclk = ~mclk;
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // cycles up to the next tick or period start, ticks counted on the way
    task automatic cycles_to(input bit st, input int lim);
        n = 0;
        nt = 0;
        do begin
            @(posedge mclk) #1;
            n++;
            nt += int'(dimming_tick_clock === 1'b1);
        end while ((st ? pwm_period_start : dimming_tick_clock) !== 1'b1
                   && n < lim);
        if (n >= lim) begin
            fail_count++;
            $display("CHECK FAILED wait exp pulse got timeout");
            complete_run();
        end
    endtask
    // one cycle of per-switch event codes, lines scrambled afterwards
    task automatic inject(input logic [23:0] s, input logic [11:0] v);
        @(posedge mclk) #1;
        switch_diag_state = s;
        switch_diag_valid = v;
        @(posedge mclk) #1;
        switch_diag_valid = 12'h000;
        switch_diag_state = ~s;
    endtask
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        resetn = 1'b0;
        channel_transition_count = 4'h0;
        switch_diag_state = 24'h000000;
        switch_diag_valid = 12'h000;
        fail_count = 0;
        n_tests = 0;
        repeat (3) @(posedge mclk);
        #1 resetn = 1'b1;
        i_pdts_host_model.read(SWITCH_DIAG_REPORT_OFFSET, 1'b1, rd_d);
        `CHK("diag_reset", 24'h000000, rd_d)
        `CHK("slope_reset", 1'b0, turn_on_slope_select)
        $display("test reset done");
        // full transition count so the extension scales with each band
        channel_transition_count = 4'hf;
        foreach (codes[i]) begin
            i_pdts_host_model.write(DIM_CONFIG_OFFSET, 24'(codes[i]) << 3);
            repeat (3) @(posedge mclk) #1;
            e = codes[i] > 20 ? 0 : codes[i];
            b = e < 8 ? 0 : e < 16 ? 1 : e < 20 ? 2 : 3;
            `CHK("event_time", 5'(2 << b), switch_event_time)
            `CHK("reserve", 8'(24 << b), transition_tick_reserve)
            `CHK("spacing", slot[b], switch_event_spacing)
            `CHK("extension", 10'(15 * slot[b]), end_extension_ticks)
            cycles_to(1'b0, 200);
            cycles_to(1'b0, 200);
            `CHK("tick_len", (b == 0 ? 32 - 2 * e : b < 3 ? 24 - e : 4)
                 * 10 / 4, n)
        end
        $display("test selector done");
        i_pdts_host_model.write(DIM_CONFIG_OFFSET, 24'h0010a0);
        repeat (2) @(posedge mclk) #1;
        `CHK("slope_steep", 1'b1, turn_on_slope_select)
        i_pdts_host_model.read(DIM_CONFIG_OFFSET, 1'b0, rd_d);
        `CHK("config_readback", 24'h0010a0, rd_d)
        cycles_to(1'b1, 20000);
        cycles_to(1'b1, 20000);
        `CHK("pwm_wrap", 10'h000, pwm_count)
        `CHK("pwm_ticks", 1024, nt)
        `CHK("pwm_cycles", 10240, n)
        i_pdts_host_model.write(DIM_CONFIG_OFFSET, 24'h0000a0);
        repeat (2) @(posedge mclk) #1;
        `CHK("slope_gentle", 1'b0, turn_on_slope_select)
        $display("test pwm and slope done");
        i_pdts_host_model.write(SWITCH_DIAG_REPORT_OFFSET, 24'hffffff);
        i_pdts_host_model.read(SWITCH_DIAG_REPORT_OFFSET, 1'b1, rd_d);
        `CHK("diag_ro", 24'h000000, rd_d)
        i_pdts_host_model.read(8'h20, 1'b0, rd_d);
        `CHK("unmapped", 24'h000000, rd_d)
        // switch n sits at bits 2n-1:2n-2; switch 4 reports ok
        ex = 24'h000000;
        ex[1:0] = DIAG_FAIL;
        ex[11:10] = DIAG_OPEN;
        ex[23:22] = DIAG_SHORT;
        inject(ex, 12'h829);
        inject(24'hffffff, 12'h001);
        i_pdts_host_model.read(SWITCH_DIAG_REPORT_OFFSET, 1'b0, rd_d);
        `CHK("diag_codes", ex, rd_d)
        i_pdts_host_model.read(SWITCH_DIAG_REPORT_OFFSET, 1'b1, rd_d);
        `CHK("diag_kept", ex, rd_d)
        i_pdts_host_model.read(SWITCH_DIAG_REPORT_OFFSET, 1'b1, rd_d);
        `CHK("diag_clear", 24'h000000, rd_d)
        $display("test diagnostics done");
        complete_run();
    end
endmodule // pixel_dimming_timing_status_tb_top

// ### logic/pdts_core.sv
// dimming tick generation, pwm period and switch diagnostic register
`timescale 1ns/10ps
// Summary of operation
// - selector picks dimming clock, high codes act as zero
// - one dimming clock period is one tick
// - pwm period is exactly 1024 ticks
// - switch event length 2,4,8,16 ticks by band
// - transition reserve is twelve event lengths
// - slope bit one gives steeper turn on
// - 24-bit read-only status, twelve 2-bit fields
// - codes ok, failed, open, short
// - successful network read clears the fields
// - selector is a writable configuration field
// - end of period prolonged by transitions times slot
module pdts_core
    import pdts_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [23:0] reg_wdata,
    input wire logic reg_rd,
    input wire logic read_ok,
    input wire logic [3:0] channel_transition_count,
    input wire logic [23:0] switch_diag_state,
    input wire logic [11:0] switch_diag_valid,
    output logic [23:0] reg_rdata,
    output logic dimming_tick_clock,
    output logic pwm_period_start,
    output logic [9:0] pwm_count,
    output logic [4:0] switch_event_time,
    output logic [7:0] transition_tick_reserve,
    output logic [5:0] switch_event_spacing,
    output logic [9:0] end_extension_ticks,
    output logic turn_on_slope_select
);
    // -------------------------------------------------------------------
    // configuration register
    // -------------------------------------------------------------------
    logic [4:0] sel_q, sel_d;
    logic slope_q, slope_d;

    // the selector and slope bit are writable at their documented offset
    always_comb begin
        sel_d = sel_q;
        slope_d = slope_q;
        if (reg_wr && reg_addr == DIM_CONFIG_OFFSET) begin
            sel_d = reg_wdata[DIM_SEL_LSB+:DIM_SEL_W];
            slope_d = reg_wdata[SLOPE_BIT];
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            sel_q <= 5'h00;
            slope_q <= 1'b0;
        end else begin
            sel_q <= sel_d;
            slope_q <= slope_d;
        end
    end

    // -------------------------------------------------------------------
    // band decode: codes above 20 fall back to code 0
    // -------------------------------------------------------------------
    pdts_band_e band;
    logic [4:0] eff_sel;
    logic [7:0] tick_len;
    always_comb begin
        eff_sel = (sel_q > 5'(MAX_SEL)) ? 5'h00 : sel_q;
        tick_len = tick_cycles(eff_sel);
        if (eff_sel < 5'h08) begin
            band = pdts_band0;
        end else if (eff_sel < 5'h10) begin
            band = pdts_band1;
        end else if (eff_sel < 5'h14) begin
            band = pdts_band2;
        end else begin
            band = pdts_band3;
        end
    end

    // -------------------------------------------------------------------
    // tick divider and pwm counter
    // -------------------------------------------------------------------
    logic [7:0] div_q, div_d;
    logic [9:0] pwm_q, pwm_d;
    logic tick_q, tick_d;
    logic start_q, start_d;
    // a new selector takes effect at once: the running div_q is compared to the new tick_len
    always_comb begin
        div_d = div_q + 8'h01;
        pwm_d = pwm_q;
        tick_d = 1'b0;
        start_d = 1'b0;
        if (div_q >= tick_len - 8'h01) begin
            div_d = 8'h00;
            tick_d = 1'b1;
            pwm_d = pwm_q + 10'h001;
            start_d = (pwm_q == PWM_LAST);
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            div_q <= 8'h00;
            pwm_q <= 10'h000;
            tick_q <= 1'b0;
            start_q <= 1'b0;
        end else begin
            div_q <= div_d;
            pwm_q <= pwm_d;
            tick_q <= tick_d;
            start_q <= start_d;
        end
    end

    // -------------------------------------------------------------------
    // derived timing outputs, registered
    // -------------------------------------------------------------------
    logic [4:0] ev_q;
    logic [7:0] tr_q;
    logic [5:0] slot_q;
    logic [9:0] ext_q;
    logic [4:0] ev_d;
    logic [7:0] tr_d;
    logic [5:0] slot_d;
    logic [9:0] ext_d;
    always_comb begin
        ev_d = SW_TICKS[band];
        tr_d = 8'(ev_d * RESERVE_MULT);
        slot_d = SWITCH_EVENT_SPACING[band];
        // widen both factors first so the product is not cut to six bits
        ext_d = 10'(channel_transition_count) * 10'(slot_d);
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ev_q <= 5'h00;
            tr_q <= 8'h00;
            slot_q <= 6'h00;
            ext_q <= 10'h000;
        end else begin
            ev_q <= ev_d;
            tr_q <= tr_d;
            slot_q <= slot_d;
            ext_q <= ext_d;
        end
    end

    // -------------------------------------------------------------------
    // switch diagnostic report, clear on a completed network read
    // -------------------------------------------------------------------
    logic [23:0] diag;
    logic diag_clear;
    // clear only when the read frame was accepted, so a lost read keeps data
    assign diag_clear = read_ok &&
                        reg_addr == SWITCH_DIAG_REPORT_OFFSET;
    pdts_diag_mem #(.N(NUM_SW)) u_diag (
        .mclk(mclk),
        .resetn(resetn),
        .diag_event(switch_diag_state),
        .diag_valid(switch_diag_valid),
        .clear(diag_clear),
        .rdata(diag)
    );

    logic [23:0] rd_q, rd_d;
    // read mux; unmapped offsets read zero
    always_comb begin
        rd_d = rd_q;
        if (reg_rd) begin
            if (reg_addr == DIM_CONFIG_OFFSET) begin
                rd_d = 24'h000000;
                rd_d[DIM_SEL_LSB+:DIM_SEL_W] = sel_q;
                rd_d[SLOPE_BIT] = slope_q;
            end else if (reg_addr == SWITCH_DIAG_REPORT_OFFSET) begin
                rd_d = diag;
            end else begin
                rd_d = 24'h000000;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            rd_q <= 24'h000000;
        end else begin
            rd_q <= rd_d;
        end
    end

    assign reg_rdata = rd_q;
    assign dimming_tick_clock = tick_q;
    assign pwm_period_start = start_q;
    assign pwm_count = pwm_q;
    assign switch_event_time = ev_q;
    assign transition_tick_reserve = tr_q;
    assign switch_event_spacing = slot_q;
    assign end_extension_ticks = ext_q;
    assign turn_on_slope_select = slope_q;

    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------
    a_slope_write: assert property (
        @(posedge mclk) disable iff (!resetn)
        (reg_wr && reg_addr == DIM_CONFIG_OFFSET) |=>
        turn_on_slope_select == $past(reg_wdata[SLOPE_BIT]))
        else $error("slope bit not written");
    // band 0 reserve is twelve events of two ticks each
    a_reserve_twelve: assert property (
        @(posedge mclk) disable iff (!resetn)
        (eff_sel < 5'h08 && $stable(eff_sel)) |=>
        transition_tick_reserve == 8'd24)
        else $error("reserve not twelve events");
    a_event_len: assert property (
        @(posedge mclk) disable iff (!resetn)
        (sel_q == 5'h14 && $stable(sel_q)) |=> switch_event_time == 5'd16)
        else $error("code 20 event length wrong");
    a_high_code: assert property (
        @(posedge mclk) disable iff (!resetn)
        sel_q > 5'h14 |-> tick_len == 8'd80)
        else $error("high code not like code 0");
    a_tick_spacing: assert property (
        @(posedge mclk) disable iff (!resetn)
        (tick_d && $stable(sel_q)) |=> !tick_d [*3])
        else $error("ticks too close");
    a_period_wrap: assert property (
        @(posedge mclk) disable iff (!resetn)
        (tick_d && pwm_q == PWM_LAST) |=> pwm_count == 10'h000 && start_q)
        else $error("period not 1024 ticks");
    // the store is cleared at the edge that samples the clear
    a_diag_clear: assert property (
        @(posedge mclk) disable iff (!resetn)
        (diag_clear && switch_diag_valid == 12'h000) |=> diag == 24'h000000)
        else $error("read did not clear");
    a_slot_code20: assert property (
        @(posedge mclk) disable iff (!resetn)
        (sel_q == 5'h14 && $stable(sel_q)) |=> switch_event_spacing == 6'd4)
        else $error("slot wrong for code 20");
endmodule // pdts_core

// ### logic/pdts_diag_mem.sv
// sticky store for the twelve switch diagnostic fields
`timescale 1ns/10ps
module pdts_diag_mem
    import pdts_pkg::*;
#(
    parameter int N = NUM_SW
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [2*N-1:0] diag_event,
    input wire logic [N-1:0] diag_valid,
    input wire logic clear,
    output logic [2*N-1:0] rdata
);
    logic [2*N-1:0] store_q, store_d;

    // -------------------------------------------------------------------
    // per switch latch; new event beats a clear in the same cycle
    // -------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_sw
            always_comb begin
                store_d[2*g+:2] = store_q[2*g+:2];
                if (clear) begin
                    store_d[2*g+:2] = DIAG_OK;
                end
                // only a non-ok code is latched; ok never hides a fault
                if (diag_valid[g] && diag_event[2*g+:2] != DIAG_OK &&
                    store_q[2*g+:2] == DIAG_OK) begin
                    store_d[2*g+:2] = diag_event[2*g+:2];
                end
                if (diag_valid[g] && diag_event[2*g+:2] != DIAG_OK &&
                    clear) begin
                    store_d[2*g+:2] = diag_event[2*g+:2];
                end
            end
        end
    endgenerate

    // registered store and read data
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            store_q <= (2*N)'(SWITCH_DIAG_RESET);
        end else begin
            store_q <= store_d;
        end
    end
    assign rdata = store_q;

    a_fault_held: assert property (
        @(posedge mclk) disable iff (!resetn)
        (store_q[1:0] != DIAG_OK && !clear) |=>
        store_q[1:0] == $past(store_q[1:0]))
        else $error("fault field changed without clear");
endmodule // pdts_diag_mem

// ### logic/pdts_pkg.sv
// constants for the pixel dimming timing and switch status block
package pdts_pkg;
    // -------------------------------------------------------------------
    // register map
    // -------------------------------------------------------------------
    localparam logic [7:0] DIM_CONFIG_OFFSET = 8'h0e;
    localparam logic [7:0] SWITCH_DIAG_REPORT_OFFSET = 8'h0f;
    localparam int DIM_SEL_LSB = 3;
    localparam int DIM_SEL_W = 5;
    localparam int SLOPE_BIT = 12;
    localparam int REG_W = 24;
    localparam int NUM_SW = 12;
    localparam logic [23:0] SWITCH_DIAG_RESET = 24'h000000;

    // -------------------------------------------------------------------
    // diagnostic codes
    // -------------------------------------------------------------------
    localparam logic [1:0] DIAG_OK = 2'h0;
    localparam logic [1:0] DIAG_FAIL = 2'h1;
    localparam logic [1:0] DIAG_OPEN = 2'h2;
    localparam logic [1:0] DIAG_SHORT = 2'h3;

    // -------------------------------------------------------------------
    // timing: clock 10 MHz; dimming tick period in 0.25 us units
    // -------------------------------------------------------------------
    localparam int MCLK_KHZ = 10000;
    localparam int PWM_TICKS = 1024;
    localparam logic [9:0] PWM_LAST = 10'h3ff;
    localparam int MAX_SEL = 20;
    // tick period in quarter microseconds per code 0..20
    localparam int TICK_QUS[21] = '{32, 30, 28, 26, 24, 22, 20, 18,
                                    16, 15, 14, 13, 12, 11, 10, 9,
                                    8, 7, 6, 5, 4};
    // cycles of mclk per quarter microsecond, a quarter of the MHz figure: 10 MHz -> 10/4
    function automatic logic [7:0] tick_cycles(input logic [4:0] sel);
        int idx;
        idx = (sel > 5'(MAX_SEL)) ? 0 : int'(sel);
        return 8'((TICK_QUS[idx] * MCLK_KHZ) / 4000);
    endfunction
    localparam logic [4:0] SW_TICKS[4] = '{5'd2, 5'd4, 5'd8, 5'd16};
    localparam logic [5:0] SWITCH_EVENT_SPACING[4] = '{6'd41, 6'd20, 6'd9, 6'd4};
    localparam int RESERVE_MULT = 12;

    typedef enum logic [1:0] {pdts_band0, pdts_band1, pdts_band2,
                              pdts_band3} pdts_band_e;
endpackage
